// *** rtl/rcc_pkg.sv ***
// Purpose: Shared constants and types for the ROM clock control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package rcc_pkg;

    // ========================================
    // Bus widths and responses
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ========================================
    // Register map
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;

    // Control register fields
    localparam int          CKE_BIT      = 16;
    localparam int          RUN_BIT      = 17;
    localparam int          DIV2_BIT     = 18;
    localparam int          CTRL_STRB    = 2;

    // Status register fields
    localparam int          ST_PD_BIT    = 0;
    localparam int          ST_CLK_BIT   = 1;
    localparam int          ST_PEND_BIT  = 2;

    // Reset values
    localparam logic        DIV2_RST     = 1'h1;
    localparam logic [1:0]  RESP_RST     = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0;

    // ========================================
    // ROM command codes
    typedef enum logic [2:0] {
        RCC_CMD_NONE,
        RCC_CMD_PDOWN,
        RCC_CMD_PDEXIT,
        RCC_CMD_MRS,
        RCC_CMD_READ,
        RCC_CMD_OTHER
    } rcc_cmd_code_t;

    // Command strobe with its code
    typedef struct packed {
        logic          valid;
        rcc_cmd_code_t code;
    } rcc_cmd_t;

    localparam rcc_cmd_t CMD_IDLE = '{valid: 1'b0, code: RCC_CMD_NONE};

endpackage : rcc_pkg

// *** rtl/rcc_top.sv ***
// Purpose: Clock, clock-enable and command gating for a sync mask ROM on bank 0
// Assumes: clk runs at four times the memory clock with divide-by-two set (its reset value), twice with it clear; inputs synchronous to clk
// Notes:   Registers reached over AXI4-Lite; one write and one read at a time

module rcc_top
    import rcc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       sleep_reset,
    input  wire logic                       sleep_enter,
    input  wire logic                       boot_bank_sync_rom_select,
    input  wire logic                       auto_req,
    input  wire rcc_pkg::rcc_cmd_code_t     auto_code,
    output      logic                       auto_ack,
    output      rcc_pkg::rcc_cmd_t          rom_cmd,
    output      logic                       rom_clock_pin,
    output      logic                       rom_clock_enable_pin,
    input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output      logic                       s_axi_awready,
    input  wire logic [rcc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output      logic                       s_axi_wready,
    output      logic [1:0]                 s_axi_bresp,
    output      logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output      logic                       s_axi_arready,
    output      logic [rcc_pkg::DATA_W-1:0] s_axi_rdata,
    output      logic [1:0]                 s_axi_rresp,
    output      logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import rcc_pkg::*;

    // ========================================
    // Declarations
    logic                 any_rst;

    // Control and ROM state
    logic                 cke_reg;
    logic                 run_reg;
    logic                 div2_reg;
    logic                 sw_pd_reg;
    logic                 phase_reg;
    logic                 clk_pin_reg;

    // Register bus and command state
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 aw_full_reg;
    logic                 w_full_reg;
    logic [ADDR_W-1:0]    awaddr_reg;
    logic [DATA_W-1:0]    wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 arready_reg;
    logic                 rvalid_reg;
    logic [1:0]           rresp_reg;
    logic [DATA_W-1:0]    rdata_reg;
    logic                 auto_ack_reg;
    rcc_cmd_t             cmd_reg;

    // Next values and decodes
    rcc_cmd_t             cmd_next;
    logic                 wr_fire;
    logic                 ctrl_wr;
    logic                 cke_next;
    logic                 run_next;
    logic                 div2_next;
    logic                 sw_cmd;
    logic                 auto_ok;
    logic [DATA_W-1:0]    rd_word;
    logic [1:0]           rd_resp;
    logic [1:0]           wr_resp;
    logic [DATA_W-1:0]    ctrl_word;
    logic [DATA_W-1:0]    status_word;

    // Hardware and sleep reset act alike on control and ROM state; the bus logic uses reset only
    assign any_rst = reset | sleep_reset;

    // ========================================
    // Write path of the register bus

    // Address channel capture
    always_ff @(posedge clk) begin
        if (reset) begin
            awready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end else if (s_axi_bready && bvalid_reg) begin
            awready_reg <= 1'b1;
        end
    end

    // Data channel capture
    always_ff @(posedge clk) begin
        if (reset) begin
            wready_reg <= 1'b1;
            w_full_reg <= 1'b0;
            wdata_reg  <= DATA_RST;
            wstrb_reg  <= '0;
        end else if (s_axi_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end else if (s_axi_bready && bvalid_reg) begin
            wready_reg <= 1'b1;
        end
    end

    // Commit once address and data are both held
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ctrl_wr = wr_fire && (awaddr_reg == CTRL_OFS) && wstrb_reg[CTRL_STRB];

    // Write response decode, status is read-only
    always_comb begin
        wr_resp = RESP_SLVERR;
        if (awaddr_reg == CTRL_OFS) begin
            wr_resp = RESP_OKAY;
        end else if (awaddr_reg == STATUS_OFS) begin
            wr_resp = RESP_OKAY;   // Write ignored
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_RST;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_resp;
        end else if (s_axi_bready && bvalid_reg) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ========================================
    // Control bits

    // Next values from a software write
    always_comb begin
        cke_next  = cke_reg;
        run_next  = run_reg;
        div2_next = div2_reg;
        if (ctrl_wr) begin
            cke_next  = wdata_reg[CKE_BIT];
            run_next  = wdata_reg[RUN_BIT];
            div2_next = wdata_reg[DIV2_BIT];
        end
    end

    // Level bit for the clock-enable pin
    always_ff @(posedge clk) begin
        if (any_rst) begin
            cke_reg <= boot_bank_sync_rom_select;
        end else if (sleep_enter) begin
            cke_reg <= 1'b0;
        end else begin
            cke_reg <= cke_next;
        end
    end

    // Run bit for the ROM clock
    always_ff @(posedge clk) begin
        if (any_rst) begin
            run_reg <= boot_bank_sync_rom_select;
        end else if (sleep_enter) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end

    // Divide-by-two bit
    always_ff @(posedge clk) begin
        if (any_rst) begin
            div2_reg <= DIV2_RST;
        end else begin
            div2_reg <= div2_next;
        end
    end

    // ========================================
    // Software power-down commands

    // Enable level changed by software while clock runs
    assign sw_cmd = ctrl_wr && !sleep_enter && run_reg && (cke_next != cke_reg);

    // Software power-down state
    always_ff @(posedge clk) begin
        if (any_rst || sleep_enter) begin
            sw_pd_reg <= 1'b0;
        end else if (sw_cmd) begin
            sw_pd_reg <= !cke_next;
        end
    end

    // Automatic command allowed now
    always_comb begin
        auto_ok = auto_req && !sw_cmd && !auto_ack_reg;
        if (!run_reg) begin
            auto_ok = 1'b0;
        end else if (sw_pd_reg && (auto_code == RCC_CMD_MRS || auto_code == RCC_CMD_READ)) begin
            auto_ok = 1'b0;
        end
    end

    // Next command strobe, software command first
    always_comb begin
        cmd_next = CMD_IDLE;
        if (sw_cmd) begin
            cmd_next.valid = 1'b1;
            cmd_next.code  = cke_next ? RCC_CMD_PDEXIT : RCC_CMD_PDOWN;
        end else if (auto_ok) begin
            cmd_next.valid = 1'b1;
            cmd_next.code  = auto_code;
        end
    end

    // Command strobe towards the ROM
    always_ff @(posedge clk) begin
        if (any_rst || sleep_enter) begin
            cmd_reg <= CMD_IDLE;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // Acknowledge to the automatic requester
    always_ff @(posedge clk) begin
        if (any_rst || sleep_enter) begin
            auto_ack_reg <= 1'b0;
        end else begin
            auto_ack_reg <= auto_ok;
        end
    end

    // ========================================
    // ROM clock generation

    // Phase for the half-rate divider
    always_ff @(posedge clk) begin
        if (any_rst || !run_reg) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
        end
    end

    // Clock pin held low while stopped
    always_ff @(posedge clk) begin
        if (any_rst || !run_reg) begin
            clk_pin_reg <= 1'b0;
        end else if (!div2_reg || phase_reg) begin
            clk_pin_reg <= !clk_pin_reg;
        end
    end

    // ========================================
    // Read path of the register bus

    // Register images seen by the read path
    always_comb begin
        ctrl_word                = DATA_RST;
        ctrl_word[CKE_BIT]       = cke_reg;
        ctrl_word[RUN_BIT]       = run_reg;
        ctrl_word[DIV2_BIT]      = div2_reg;
        status_word              = DATA_RST;
        status_word[ST_PD_BIT]   = sw_pd_reg;
        status_word[ST_CLK_BIT]  = clk_pin_reg;
        status_word[ST_PEND_BIT] = auto_req && !auto_ok && !auto_ack_reg;
    end

    // Read decode
    always_comb begin
        rd_word = DATA_RST;
        rd_resp = RESP_OKAY;
        if (s_axi_araddr == CTRL_OFS) begin
            rd_word = ctrl_word;
        end else if (s_axi_araddr == STATUS_OFS) begin
            rd_word = status_word;
        end else begin
            rd_resp = RESP_SLVERR;
        end
    end

    // Address accept and data return
    always_ff @(posedge clk) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_RST;
            rdata_reg   <= DATA_RST;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= rd_resp;
            rdata_reg   <= rd_word;
        end else if (s_axi_rready && rvalid_reg) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ========================================
    // Outputs
    assign s_axi_awready        = awready_reg;
    assign s_axi_wready         = wready_reg;
    assign s_axi_bvalid         = bvalid_reg;
    assign s_axi_bresp          = bresp_reg;
    assign s_axi_arready        = arready_reg;
    assign s_axi_rvalid         = rvalid_reg;
    assign s_axi_rresp          = rresp_reg;
    assign s_axi_rdata          = rdata_reg;
    assign auto_ack             = auto_ack_reg;
    assign rom_cmd              = cmd_reg;
    assign rom_clock_pin        = clk_pin_reg;
    assign rom_clock_enable_pin = cke_reg;

endmodule : rcc_top

// *** tb/rcc_checker.sv ***
// Purpose: Port assertions for rcc_top
// Assumes: Bound to every rcc_top
// Notes:   Sees top ports only
module rcc_checker
    import rcc_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   sleep_reset,
    input wire logic                   sleep_enter,
    input wire logic                   boot_bank_sync_rom_select,
    input wire rcc_pkg::rcc_cmd_code_t auto_code,
    input wire logic                   auto_ack,
    input wire rcc_pkg::rcc_cmd_t      rom_cmd,
    input wire logic                   rom_clock_pin,
    input wire logic                   rom_clock_enable_pin
);
    import rcc_pkg::*;
    logic [3:0] cnt;
    logic       pd_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ========================================
    // Cycles since any reset, saturating
    always_ff @(posedge clk) begin
        if (reset || sleep_reset)
            cnt <= 4'h0;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;
    end
    // Software power-down as issued to the ROM
    always_ff @(posedge clk) begin
        if (reset || sleep_reset || sleep_enter) begin
            pd_seen <= 1'b0;
        end else if (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDOWN) begin
            pd_seen <= 1'b1;
        end else if (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDEXIT) begin
            pd_seen <= 1'b0;
        end
    end
    a_sleep_cke_clr: assert property (sleep_enter && !sleep_reset |=> !rom_clock_enable_pin)
        else $error("enable pin not cleared on sleep");
    a_strap_cke: assert property (sleep_reset |=> rom_clock_enable_pin == $past(boot_bank_sync_rom_select))
        else $error("enable pin not loaded from strap");
    a_sleep_run_clr: assert property (sleep_enter && !sleep_reset |=> ##1 !rom_clock_pin)
        else $error("clock pin runs after sleep");
    a_strap_run: assert property (sleep_reset && !boot_bank_sync_rom_select |=> ##1 !rom_clock_pin)
        else $error("clock pin runs with strap clear");
    a_half_start: assert property ($changed(rom_clock_pin) && cnt >= 4'h2 && cnt < 4'ha |=> $stable(rom_clock_pin))
        else $error("clock not at half rate after reset");
    a_pd_cke_low: assert property (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDOWN |-> !rom_clock_enable_pin)
        else $error("power-down with enable high");
    a_pdx_cke_high: assert property (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDEXIT |-> rom_clock_enable_pin)
        else $error("power-down exit with enable low");
    a_pd_no_auto: assert property (rom_cmd.valid && rom_cmd.code inside {RCC_CMD_MRS, RCC_CMD_READ} |-> !pd_seen)
        else $error("mode-set or read while powered down");
    a_ack_fwd: assert property (auto_ack |-> rom_cmd.valid && rom_cmd.code == $past(auto_code))
        else $error("acked request not forwarded");
endmodule : rcc_checker

bind rcc_top rcc_checker i_rcc_checker (.clk, .reset, .sleep_reset, .sleep_enter, .boot_bank_sync_rom_select,
    .auto_code, .auto_ack, .rom_cmd, .rom_clock_pin, .rom_clock_enable_pin);

// *** tb/rcc_rom_model.sv ***
// Purpose: Behavioural sync mask ROM command receiver
// Assumes: Commands arrive as one-cycle strobes
// Notes:   Flags mode-set or read while powered down
module rcc_rom_model
    import rcc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire rcc_pkg::rcc_cmd_t rom_cmd,
    output logic                   pd_state,
    output logic                   bad
);
    import rcc_pkg::*;
    initial bad = 1'b0;
    // ========================================
    // Power-down entered and left by command
    always @(posedge clk) begin
        if (rst)
            pd_state <= 1'b0;
        else if (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDOWN)
            pd_state <= 1'b1;
        else if (rom_cmd.valid && rom_cmd.code == RCC_CMD_PDEXIT)
            pd_state <= 1'b0;
    end
    // Illegal access while powered down
    always @(posedge clk) begin
        if (pd_state && rom_cmd.valid && rom_cmd.code inside {RCC_CMD_MRS, RCC_CMD_READ})
            bad <= 1'b1;
    end
endmodule : rcc_rom_model

// *** tb/tb.sv ***
// Purpose: Self-checking bench for rcc_top
// Assumes: 40 MHz clock, AXI4-Lite master tasks
// Notes:   Scenarios are tasks run in sequence
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rcc_pkg::*;
    localparam logic [31:0] CK = 32'h1 << CKE_BIT;
    localparam logic [31:0] RN = 32'h1 << RUN_BIT;
    localparam logic [31:0] DV = 32'h1 << DIV2_BIT;
    logic clk = 1'b0, reset = 1'b1, sleep_reset = 1'b0, sleep_enter = 1'b0, boot = 1'b0;
    logic auto_req = 1'b0, auto_ack, cke, pin, pd, bad;
    rcc_cmd_code_t auto_code = RCC_CMD_READ;
    rcc_cmd_t rom_cmd;
    logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int mismatches = 0, n_compared = 0;
    // ========================================
    // Design, ROM model and clock
    rcc_top i_rcc_top (.clk, .reset, .sleep_reset, .sleep_enter, .boot_bank_sync_rom_select(boot), .auto_req,
        .auto_code, .auto_ack, .rom_cmd, .rom_clock_pin(pin), .rom_clock_enable_pin(cke), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rcc_rom_model i_rcc_rom_model (.clk, .rst(reset | sleep_reset | sleep_enter), .rom_cmd, .pd_state(pd), .bad);
    always #12.5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // AXI4-Lite write, each channel released when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("write answer", 1, bvalid);
        chk("write response", RESP_OKAY, bresp);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk("read answer", 1, rvalid);
    endtask : rd
    task automatic t_auto(input rcc_cmd_code_t c, input logic e, input string nm);
        logic g;
        g = 1'b0;
        @(posedge clk);
        auto_req <= 1'b1;
        auto_code <= c;
        for (int n = 0; n < 6 && g !== 1'b1; n++) begin
            @(posedge clk);
            g = auto_ack;
        end
        auto_req <= 1'b0;
        chk(nm, e, g);
    endtask : t_auto
    task automatic toggles(input int n, output int c);
        logic p;
        c = 0;
        p = pin;
        repeat (n) begin
            @(posedge clk);
            if (pin !== p) c++;
            p = pin;
        end
    endtask : toggles
    // ========================================
    // Scenarios
    task automatic t_boot(input logic b);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        reset <= 1'b1;
        boot <= b;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(CTRL_OFS, d, r);
        chk("ctrl after reset", DV | (b ? CK | RN : 32'h0), d);
        chk("enable pin", b, cke);
    endtask : t_boot
    task automatic t_rate;
        int c;
        toggles(16, c);
        chk("half rate toggles", 8, c);
        wr(CTRL_OFS, CK | RN);
        toggles(16, c);
        chk("full rate toggles", 16, c);
        wr(CTRL_OFS, CK | RN | DV);
    endtask : t_rate
    task automatic t_pdown;
        logic [31:0] d;
        logic [1:0] r;
        wr(CTRL_OFS, RN | DV);
        for (int n = 0; n < 8 && pd !== 1'b1; n++) @(posedge clk);
        chk("power-down command", 1, pd);
        rd(STATUS_OFS, d, r);
        chk("status power-down", 1, d[ST_PD_BIT]);
        t_auto(RCC_CMD_READ, 1'b0, "read in power-down");
        t_auto(RCC_CMD_MRS, 1'b0, "mode-set in power-down");
        t_auto(RCC_CMD_OTHER, 1'b1, "other in power-down");
        wr(CTRL_OFS, CK | RN | DV);
        for (int n = 0; n < 8 && pd !== 1'b0; n++) @(posedge clk);
        chk("power-down exit", 0, pd);
        t_auto(RCC_CMD_READ, 1'b1, "read after exit");
    endtask : t_pdown
    task automatic t_stop;
        int c;
        wr(CTRL_OFS, CK | DV);
        for (int n = 0; n < 8 && pin !== 1'b0; n++) @(posedge clk);
        toggles(8, c);
        chk("stopped toggles", 0, c);
        t_auto(RCC_CMD_OTHER, 1'b0, "auto while stopped");
        wr(CTRL_OFS, CK | RN | DV);
    endtask : t_stop
    task automatic t_sleep;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        sleep_enter <= 1'b1;
        @(posedge clk);
        sleep_enter <= 1'b0;
        rd(CTRL_OFS, d, r);
        chk("ctrl after sleep", DV, d);
        rd(4'h8, d, r);
        chk("unmapped response", RESP_SLVERR, r);
        wr(CTRL_OFS, 32'h0);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            sleep_reset <= 1'b1;
            boot <= b[0];
            @(posedge clk);
            sleep_reset <= 1'b0;
            rd(CTRL_OFS, d, r);
            chk("ctrl after sleep reset", DV | (b[0] ? CK | RN : 32'h0), d);
        end
    endtask : t_sleep
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        t_boot(1'b0);
        t_boot(1'b1);
        t_rate;
        t_pdown;
        t_stop;
        t_sleep;
        chk("rom protocol", 0, bad);
        report_and_stop;
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
endmodule : tb
